// ---- inc/link_pkg.sv ----
package link_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ     = 25_000_000;
  localparam int BAUD_SLOW  = 19200;
  localparam int BAUD_FAST  = 115200;
  localparam int DIV_SLOW   = CLK_HZ / BAUD_SLOW;
  localparam int DIV_FAST   = CLK_HZ / BAUD_FAST;
  localparam int REPORT_MS  = 1000;
  localparam int REPORT_CYC = (CLK_HZ / 1000) * REPORT_MS;

  // ----------------------------------------
  // Packet limits
  // ----------------------------------------
  localparam int MAX_LEN       = 18;
  localparam int PING_MAX      = 16;
  localparam int MAX_SENSORS   = 32;
  localparam int BRIDGE_TX_MAX = 15;
  localparam int BRIDGE_RX_MAX = 14;
  localparam int CFG_LEN       = 4;

  // ----------------------------------------
  // Type codes
  // ----------------------------------------
  localparam logic [7:0]  RSP_FLAG     = 8'h40;
  localparam logic [7:0]  ERR_FLAG     = 8'hc0;
  localparam logic [7:0]  KEY_RPT      = 8'h80;
  localparam logic [7:0]  TEMP_RPT     = 8'h82;
  localparam logic [5:0]  CMD_PING     = 6'h00;
  localparam logic [5:0]  CMD_TEMP_CFG = 6'h13;
  localparam logic [5:0]  CMD_BRIDGE   = 6'h14;
  localparam logic [5:0]  CMD_BAUD     = 6'h21;
  localparam logic [7:0]  KEY_LEN      = 8'h01;
  localparam logic [7:0]  TEMP_LEN     = 8'h04;

  // ----------------------------------------
  // Check sequence
  // ----------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] counts;
    logic        crc_ok;
  } temp_reading_type;

  typedef struct packed {
    logic [4:0] sensor;
    logic [3:0] tx_len;
    logic [3:0] rx_len;
  } bridge_req_type;

  // Reflected 16-bit update over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ---- rtl/byte_buffer.sv ----
`timescale 1ns/100ps
module byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // ----------------------------------------
  // Flags and pointers
  // ----------------------------------------
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointer values
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

endmodule

// ---- rtl/packet_link.sv ----
// How it works
// - Line starts at 19200 baud, eight data bits, no parity, one stop bit.
// - A baud command switches both directions to 115200 baud (payload 1) or back to 19200 baud (payload 0).
// - Packets go type, length, payload, check field, in that order.
// - The first byte names the packet kind and its function.
// - Length byte counts payload bytes; only 0 to 18 allowed.
// - Check is 16-bit over type, length and payload only.
// - Check field goes low byte first, then high byte.
// - Check field follows last used payload byte, no padding.
// - Every received command is answered well within 250 ms.
// - No flow-control lines; pacing by answers alone.
// - Reports may go out any time, between answers.
// - Each enabled temperature sensor is refreshed and reported once per second.
// - Sensor bus holds at most 32 devices.
// - Bridge transactions send at most 15 and receive at most 14 bytes.
// - Each command gets exactly one answer, normal or error.
// - Answer type keeps the command's low six bits; normal adds 0x40.
// - Key reports use type 0x80, temperature reports 0x82.
`timescale 1ns/100ps
module packet_link #(
  parameter int REPORT_CYC = link_pkg::REPORT_CYC,
  parameter int DIV_SLOW   = link_pkg::DIV_SLOW,
  parameter int DIV_FAST   = link_pkg::DIV_FAST
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Serial pins
  input  wire logic                       rxd,
  output logic                            txd,
  // Key events
  input  wire logic                       key_valid,
  input  wire logic [7:0]                 key_code,
  // Temperature sensors
  output logic                            temp_refresh,
  output logic [4:0]                      temp_index,
  input  wire link_pkg::temp_reading_type temp_reading,
  // Sensor bus bridge
  output logic                            bridge_req,
  output link_pkg::bridge_req_type        bridge_info,
  // Status
  output logic                            baud_fast
);
  typedef enum {P_TYPE, P_LEN, P_DATA, P_CRCL, P_CRCH} parse_type;
  typedef enum {B_IDLE, B_TYPE, B_LEN, B_DATA, B_CRCL, B_CRCH} build_type;
  typedef enum {K_ACK, K_KEY, K_TEMP} kind_type;

  // Lowest set bit of the sensor scan set
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction

  // ----------------------------------------
  // Receive synchroniser and byte receiver
  // ----------------------------------------
  logic        s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
  logic        rbusy_reg, rbusy_next;
  logic [15:0] rcnt_reg, rcnt_next, div;
  logic [3:0]  rbit_reg, rbit_next;
  logic [7:0]  rsh_reg, rsh_next;
  logic        rstb_reg, rstb_next;
  logic        baud_reg, baud_next;

  assign div = baud_reg ? 16'(DIV_FAST) : 16'(DIV_SLOW);

  // Bit sampling at mid bit, 8N1 framing
  always_comb begin
    lvl_next   = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    rbusy_next = rbusy_reg;
    rcnt_next  = rcnt_reg;
    rbit_next  = rbit_reg;
    rsh_next   = rsh_reg;
    rstb_next  = 1'b0;
    if (!rbusy_reg) begin
      if (!lvl_reg) begin
        rbusy_next = 1'b1;
        rcnt_next  = div >> 1;
        rbit_next  = '0;
      end
    end else if (rcnt_reg != '0) begin
      rcnt_next = rcnt_reg - 1'b1;
    end else begin
      rcnt_next = div - 1'b1;
      if (rbit_reg == 4'h0) begin
        rbusy_next = !lvl_reg;
        rbit_next  = 4'h1;
      end else if (rbit_reg <= 4'h8) begin
        rsh_next  = {lvl_reg, rsh_reg[7:1]};
        rbit_next = rbit_reg + 1'b1;
      end else begin
        rbusy_next = 1'b0;
        rstb_next  = lvl_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      lvl_reg   <= 1'b1;
      rbusy_reg <= 1'b0;
      rcnt_reg  <= '0;
      rbit_reg  <= '0;
      rsh_reg   <= '0;
      rstb_reg  <= 1'b0;
    end else begin
      s1_reg    <= rxd;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= lvl_next;
      rbusy_reg <= rbusy_next;
      rcnt_reg  <= rcnt_next;
      rbit_reg  <= rbit_next;
      rsh_reg   <= rsh_next;
      rstb_reg  <= rstb_next;
    end
  end

  // ----------------------------------------
  // Packet parser
  // ----------------------------------------
  parse_type   p_reg, p_next;
  logic [4:0]  pidx_reg, pidx_next;
  logic [7:0]  ptype_reg, ptype_next, plen_reg, plen_next, pcl_reg, pcl_next;
  logic [15:0] pcrc_reg, pcrc_next;
  logic        pend_reg, pend_next, ack_done;
  logic [7:0]  ctype_reg, ctype_next, clen_reg, clen_next;
  logic [7:0]  rx_mem [link_pkg::MAX_LEN];

  always_comb begin
    p_next     = p_reg;
    pidx_next  = pidx_reg;
    ptype_next = ptype_reg;
    plen_next  = plen_reg;
    pcl_next   = pcl_reg;
    pcrc_next  = pcrc_reg;
    pend_next  = pend_reg && !ack_done;
    ctype_next = ctype_reg;
    clen_next  = clen_reg;
    if (rstb_reg) begin
      pcrc_next = link_pkg::crc_byte(pcrc_reg, rsh_reg);
      case (p_reg)
        P_TYPE: begin
          ptype_next = rsh_reg;
          pcrc_next  = link_pkg::crc_byte(link_pkg::CRC_INIT, rsh_reg);
          p_next     = P_LEN;
        end
        P_LEN: begin
          plen_next = rsh_reg;
          pidx_next = '0;
          if (rsh_reg > 8'(link_pkg::MAX_LEN)) begin
            p_next = P_TYPE;
          end else begin
            p_next = (rsh_reg == 8'h00) ? P_CRCL : P_DATA;
          end
        end
        P_DATA: begin
          pidx_next = pidx_reg + 1'b1;
          if (8'(pidx_reg) + 8'h01 == plen_reg) begin
            p_next = P_CRCL;
          end
        end
        P_CRCL: begin
          pcl_next  = rsh_reg;
          pcrc_next = pcrc_reg;
          p_next    = P_CRCH;
        end
        P_CRCH: begin
          pcrc_next = pcrc_reg;
          p_next    = P_TYPE;
          if ({rsh_reg, pcl_reg} == ~pcrc_reg && !pend_reg) begin
            pend_next  = 1'b1;
            ctype_next = ptype_reg;
            clen_next  = plen_reg;
          end
        end
        default: p_next = P_TYPE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p_reg     <= P_TYPE;
      pidx_reg  <= '0;
      ptype_reg <= '0;
      plen_reg  <= '0;
      pcl_reg   <= '0;
      pcrc_reg  <= link_pkg::CRC_INIT;
      pend_reg  <= 1'b0;
      ctype_reg <= '0;
      clen_reg  <= '0;
    end else begin
      p_reg     <= p_next;
      pidx_reg  <= pidx_next;
      ptype_reg <= ptype_next;
      plen_reg  <= plen_next;
      pcl_reg   <= pcl_next;
      pcrc_reg  <= pcrc_next;
      pend_reg  <= pend_next;
      ctype_reg <= ctype_next;
      clen_reg  <= clen_next;
    end
  end

  // Payload store, frozen while an answer is owed
  always_ff @(posedge clk_sys) begin
    if (rstb_reg && p_reg == P_DATA && !pend_reg) begin
      rx_mem[pidx_reg] <= rsh_reg;
    end
  end

  // ----------------------------------------
  // Command decode for the owed answer
  // ----------------------------------------
  logic [5:0] code;
  logic       cmd_ok, is_bridge, is_baud, is_cfg;
  logic [7:0] rsp_len;

  always_comb begin
    code      = ctype_reg[5:0];
    cmd_ok    = 1'b0;
    is_bridge = 1'b0;
    is_baud   = 1'b0;
    is_cfg    = 1'b0;
    rsp_len   = 8'h00;
    case (code)
      link_pkg::CMD_PING: begin
        cmd_ok  = clen_reg <= 8'(link_pkg::PING_MAX);
        rsp_len = clen_reg;
      end
      link_pkg::CMD_TEMP_CFG: begin
        is_cfg = clen_reg == 8'(link_pkg::CFG_LEN);
        cmd_ok = is_cfg;
      end
      link_pkg::CMD_BRIDGE: begin
        is_bridge = clen_reg >= 8'h02
                    && rx_mem[0] < 8'(link_pkg::MAX_SENSORS)
                    && rx_mem[1] <= 8'(link_pkg::BRIDGE_RX_MAX)
                    && clen_reg - 8'h02 <= 8'(link_pkg::BRIDGE_TX_MAX);
        cmd_ok    = is_bridge;
      end
      link_pkg::CMD_BAUD: begin
        is_baud = clen_reg == 8'h01 && rx_mem[0] <= 8'h01;
        cmd_ok  = is_baud;
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Packet builder
  // ----------------------------------------
  build_type   b_reg, b_next;
  kind_type    kind_reg, kind_next;
  logic [7:0]  btype_reg, btype_next, blen_reg, blen_next, bbyte;
  logic [4:0]  bidx_reg, bidx_next;
  logic [15:0] bcrc_reg, bcrc_next;
  logic [31:0] rpt_reg, rpt_next, mask_reg, mask_next, scan_reg, scan_next;
  logic        keyp_reg, keyp_next;
  logic [7:0]  keyc_reg, keyc_next;
  logic        bpend_reg, bpend_next, breq_reg, breq_next, sec_tick;
  logic        in_valid, in_ready, out_valid, out_ready, tx_idle;
  logic [7:0]  out_data;
  logic [31:0] sec_reg, sec_next;

  // Byte offered to the buffer
  always_comb begin
    case (b_reg)
      B_TYPE:  bbyte = btype_reg;
      B_LEN:   bbyte = blen_reg;
      B_DATA:  bbyte = (kind_reg == K_ACK) ? rx_mem[bidx_reg] : rpt_reg[8*bidx_reg[1:0] +: 8];
      B_CRCL:  bbyte = ~bcrc_reg[7:0];
      B_CRCH:  bbyte = ~bcrc_reg[15:8];
      default: bbyte = 8'h00;
    endcase
  end

  assign in_valid = (b_reg != B_IDLE);
  assign ack_done = (b_reg == B_CRCH) && in_ready && kind_reg == K_ACK;
  assign sec_tick = (sec_reg == 32'(REPORT_CYC - 1));

  always_comb begin
    b_next     = b_reg;
    kind_next  = kind_reg;
    btype_next = btype_reg;
    blen_next  = blen_reg;
    bidx_next  = bidx_reg;
    bcrc_next  = bcrc_reg;
    rpt_next   = rpt_reg;
    mask_next  = mask_reg;
    scan_next  = scan_reg;
    keyp_next  = keyp_reg;
    keyc_next  = keyc_reg;
    bpend_next = bpend_reg;
    breq_next  = 1'b0;
    baud_next  = baud_reg;
    sec_next   = sec_tick ? '0 : sec_reg + 1'b1;
    case (b_reg)
      B_IDLE: begin
        bidx_next = '0;
        bcrc_next = link_pkg::CRC_INIT;
        if (pend_reg) begin
          kind_next  = K_ACK;
          btype_next = {cmd_ok ? link_pkg::RSP_FLAG[7:6] : link_pkg::ERR_FLAG[7:6], code};
          blen_next  = cmd_ok ? rsp_len : 8'h00;
          b_next     = B_TYPE;
          if (is_cfg) begin
            mask_next = {rx_mem[3], rx_mem[2], rx_mem[1], rx_mem[0]};
          end
          bpend_next = is_baud;
          breq_next  = is_bridge;
        end else if (keyp_reg) begin
          kind_next  = K_KEY;
          btype_next = link_pkg::KEY_RPT;
          blen_next  = link_pkg::KEY_LEN;
          rpt_next   = {24'h000000, keyc_reg};
          keyp_next  = 1'b0;
          b_next     = B_TYPE;
        end else if (scan_reg != '0) begin
          kind_next  = K_TEMP;
          btype_next = link_pkg::TEMP_RPT;
          blen_next  = link_pkg::TEMP_LEN;
          rpt_next   = {7'h00, temp_reading.crc_ok, temp_reading.counts,
                        3'h0, first_set(scan_reg)};
          scan_next[first_set(scan_reg)] = 1'b0;
          b_next     = B_TYPE;
        end
      end
      default: begin
        if (in_ready) begin
          if (b_reg != B_CRCL) begin // Low check byte stays out of the sum; high byte folds in after use
            bcrc_next = link_pkg::crc_byte(bcrc_reg, bbyte);
          end
          case (b_reg)
            B_TYPE: b_next = B_LEN;
            B_LEN:  b_next = (blen_reg == 8'h00) ? B_CRCL : B_DATA;
            B_DATA: begin
              bidx_next = bidx_reg + 1'b1;
              if (8'(bidx_reg) + 8'h01 == blen_reg) b_next = B_CRCL;
            end
            B_CRCL: b_next = B_CRCH;
            default: b_next = B_IDLE;
          endcase
        end
      end
    endcase
    if (key_valid) begin
      keyp_next = 1'b1;
      keyc_next = key_code;
    end
    if (sec_tick) begin
      scan_next = scan_next | mask_reg;
    end
    if (bpend_reg && b_reg == B_IDLE && !pend_reg && !out_valid && tx_idle) begin
      baud_next  = rx_mem[0][0];
      bpend_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_reg     <= B_IDLE;
      kind_reg  <= K_ACK;
      btype_reg <= '0;
      blen_reg  <= '0;
      bidx_reg  <= '0;
      bcrc_reg  <= link_pkg::CRC_INIT;
      rpt_reg   <= '0;
      mask_reg  <= '0;
      scan_reg  <= '0;
      keyp_reg  <= 1'b0;
      keyc_reg  <= '0;
      bpend_reg <= 1'b0;
      breq_reg  <= 1'b0;
      baud_reg  <= 1'b0;
      sec_reg   <= '0;
    end else begin
      b_reg     <= b_next;
      kind_reg  <= kind_next;
      btype_reg <= btype_next;
      blen_reg  <= blen_next;
      bidx_reg  <= bidx_next;
      bcrc_reg  <= bcrc_next;
      rpt_reg   <= rpt_next;
      mask_reg  <= mask_next;
      scan_reg  <= scan_next;
      keyp_reg  <= keyp_next;
      keyc_reg  <= keyc_next;
      bpend_reg <= bpend_next;
      breq_reg  <= breq_next;
      baud_reg  <= baud_next;
      sec_reg   <= sec_next;
    end
  end

  // Bridge request fields
  logic [4:0] brs_reg;
  logic [3:0] brt_reg, brr_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brs_reg <= '0;
      brt_reg <= '0;
      brr_reg <= '0;
    end else if (breq_next) begin
      brs_reg <= rx_mem[0][4:0];
      brr_reg <= rx_mem[1][3:0];
      brt_reg <= 4'(clen_reg - 8'h02);
    end
  end

  // Two-entry buffer between builder and line driver
  byte_buffer #(.WIDTH(8), .DEPTH(2)) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (bbyte),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // ----------------------------------------
  // Transmit line driver
  // ----------------------------------------
  logic [15:0] tdiv_reg, tdiv_next;
  logic [9:0]  tsh_reg, tsh_next;
  logic [3:0]  tbits_reg, tbits_next;
  logic        txd_reg, txd_next, ttick;

  assign tx_idle   = (tbits_reg == 4'h0);
  assign out_ready = tx_idle;
  assign ttick     = (tdiv_reg == '0);

  // Bit-rate enable and 8N1 shifter
  always_comb begin
    tdiv_next  = ttick ? div - 1'b1 : tdiv_reg - 1'b1;
    tsh_next   = tsh_reg;
    tbits_next = tbits_reg;
    txd_next   = txd_reg;
    if (tx_idle && out_valid) begin
      tsh_next   = {1'b1, out_data, 1'b0};
      tbits_next = 4'ha;
    end else if (ttick) begin
      txd_next = tx_idle ? 1'b1 : tsh_reg[0];
      if (!tx_idle) begin
        tsh_next   = {1'b1, tsh_reg[9:1]};
        tbits_next = tbits_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tdiv_reg  <= '0;
      tsh_reg   <= '1;
      tbits_reg <= '0;
      txd_reg   <= 1'b1;
    end else begin
      tdiv_reg  <= tdiv_next;
      tsh_reg   <= tsh_next;
      tbits_reg <= tbits_next;
      txd_reg   <= txd_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic       trf_reg;
  logic [4:0] tix_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trf_reg <= 1'b0;
      tix_reg <= '0;
    end else begin
      trf_reg <= sec_tick;
      tix_reg <= first_set(scan_next);
    end
  end

  assign txd          = txd_reg;
  assign temp_refresh = trf_reg;
  assign temp_index   = tix_reg;
  assign bridge_req   = breq_reg;
  assign bridge_info  = '{sensor: brs_reg, tx_len: brt_reg, rx_len: brr_reg};
  assign baud_fast    = baud_reg;

endmodule

// ---- verif/link_sva.sv ----
`timescale 1ns/100ps
module link_sva #(
  parameter int REPORT_CYC = 2000,
  parameter int DIV_SLOW   = link_pkg::DIV_SLOW,
  parameter int DIV_FAST   = link_pkg::DIV_FAST
) (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  // Watched outputs
  input wire logic                     txd,
  input wire logic                     temp_refresh,
  input wire logic                     bridge_req,
  input wire link_pkg::bridge_req_type bridge_info,
  input wire logic                     baud_fast
);
  int   per_reg, per_next, low_reg, low_next, div;
  logic seen_reg, seen_next;
  // Refresh spacing and low run length on txd
  always_comb begin
    per_next  = temp_refresh ? 0 : per_reg + 1;
    seen_next = seen_reg | temp_refresh;
    low_next  = txd ? 0 : low_reg + 1;
    div       = baud_fast ? DIV_FAST : DIV_SLOW;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_reg  <= 0;
      seen_reg <= 1'b0;
      low_reg  <= 0;
    end else begin
      per_reg  <= per_next;
      seen_reg <= seen_next;
      low_reg  <= low_next;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_idle_after_reset: assert property ($rose(rst_n) |-> txd && !baud_fast && !bridge_req)
    else $error("line not quiet after reset");
  chk_refresh_pulse: assert property (temp_refresh |=> !temp_refresh)
    else $error("refresh pulse too long");
  chk_refresh_period: assert property (temp_refresh && seen_reg |-> per_reg == REPORT_CYC - 1)
    else $error("refresh spacing wrong");
  chk_bridge_pulse: assert property (bridge_req |=> !bridge_req)
    else $error("bridge pulse too long");
  chk_bridge_limits: assert property (bridge_req |=> bridge_info.tx_len <= 15 &&
    bridge_info.rx_len <= 14 && $stable(bridge_info))
    else $error("bridge counts over limit");
  chk_baud_idle: assert property ($changed(baud_fast) |-> txd && $past(txd))
    else $error("rate changed mid frame");
  chk_bit_timing: assert property (txd && low_reg != 0 |-> low_reg % div == 0 &&
    low_reg <= 9 * div)
    else $error("low run not whole bits");
  chk_stop_bit: assert property ($rose(txd) |=> txd [*8])
    else $error("stop bit cut short");
endmodule

// ---- verif/link_host.sv ----
`timescale 1ns/100ps
module link_host #(
  parameter int DIV_SLOW = link_pkg::DIV_SLOW
) (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic     rxd,
  input wire logic txd
);
  int         div = DIV_SLOW;
  logic [7:0] rx_q[$];
  logic [7:0] r;
  initial rxd = 1'b1;
  // Reflected check, preset ones, inverted
  function automatic logic [15:0] crc16(logic [7:0] b[$]);
    logic [15:0] c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  // Send bytes; mode 0 raw, 1 bad check, 2 good check
  task automatic send(logic [7:0] b[$], int mode);
    logic [15:0] c;
    logic [9:0]  f;
    c = crc16(b);
    if (mode > 0) begin
      b.push_back(c[7:0] ^ {7'h0, mode == 1});
      b.push_back(c[15:8]);
    end
    @(negedge clk_sys);
    foreach (b[i]) begin
      f = {1'b1, b[i], 1'b0};
      for (int k = 0; k < 10; k++) begin
        rxd = f[k];
        repeat (div) @(negedge clk_sys);
      end
    end
  endtask
  // Byte capture from the device pin
  initial forever begin
    @(negedge txd);
    repeat (div / 2) @(posedge clk_sys);
    for (int k = 0; k < 8; k++) begin
      repeat (div) @(posedge clk_sys);
      r[k] = txd;
    end
    repeat (div) @(posedge clk_sys);
    rx_q.push_back(r);
  end
  // Take one packet, bounded wait, check field stripped
  task automatic get(output logic [7:0] p[$], output bit ok);
    int n;
    n = 0;
    p = {};
    ok = 0;
    while ((rx_q.size() < 2 || rx_q.size() < rx_q[1] + 4) && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n < 20000) begin
      repeat (rx_q[1] + 4) p.push_back(rx_q.pop_front());
      ok = crc16(p[0:$-2]) === {p[$], p[$-1]};
      p = p[0:$-2];
    end
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic                     clk_sys, rst_n, key_valid, rxd, txd, req_d;
  logic                     temp_refresh, bridge_req, baud_fast;
  logic [7:0]               key_code, p[$];
  logic [4:0]               temp_index;
  link_pkg::bridge_req_type bridge_info, br_info;
  int                       num_errors = 0, check_count = 0, br_cnt = 0;
  bit                       ok;
  // Short bit times at the same rate ratio keep the run brief
  localparam int SLOW = 96;
  localparam int FAST = 16;
  packet_link #(.REPORT_CYC(10000), .DIV_SLOW(SLOW), .DIV_FAST(FAST)) dut (.clk_sys, .rst_n,
    .rxd, .txd, .key_valid, .key_code, .temp_refresh, .temp_index,
    .temp_reading({8'h3c, 3'h0, temp_index, 1'b1}), .bridge_req, .bridge_info, .baud_fast);
  link_host #(.DIV_SLOW(SLOW)) host (.clk_sys, .rxd, .txd);
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Latch bridge details one cycle after the pulse
  always @(posedge clk_sys) begin
    req_d <= bridge_req;
    if (req_d) begin
      br_info <= bridge_info;
      br_cnt++;
    end
  end
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_pkt(logic [7:0] e[$]);
    host.get(p, ok);
    cmp(ok, 1);
    cmp(p.size(), e.size());
    foreach (e[i]) cmp(p[i], e[i]);
  endtask
  task automatic t_baud;
    host.send({8'h21, 8'h01, 8'h01}, 2);
    expect_pkt({8'h61, 8'h00});
    host.div = FAST;
    repeat (1000) @(negedge clk_sys);
    cmp(baud_fast, 1);
  endtask
  task automatic t_ping;
    logic [7:0] b[$];
    b = {8'h00, 8'h10};
    for (int i = 0; i < 16; i++) b.push_back(8'ha0 + i[7:0]);
    host.send(b, 2);
    b[0] = 8'h40;
    expect_pkt(b);
  endtask
  task automatic t_bad;
    host.send({8'h00, 8'h13}, 0);
    host.send({8'h00, 8'h00}, 1);
    host.send({8'h00, 8'h01, 8'h5a}, 2);
    expect_pkt({8'h40, 8'h01, 8'h5a});
    repeat (3000) @(negedge clk_sys);
    cmp(host.rx_q.size(), 0);
  endtask
  task automatic t_key;
    @(negedge clk_sys);
    key_valid = 1;
    key_code = 8'h05;
    @(negedge clk_sys);
    key_valid = 0;
    expect_pkt({8'h80, 8'h01, 8'h05});
  endtask
  task automatic t_bridge(logic [7:0] rx, logic [7:0] ty);
    logic [7:0] b[$];
    b = {8'h14, 8'h11, 8'h1f, rx};
    repeat (15) b.push_back(8'h33);
    host.send(b, 2);
    expect_pkt({ty, 8'h00});
  endtask
  task automatic t_temp;
    host.send({8'h13, 8'h04, 8'h05, 8'h00, 8'h00, 8'h00}, 2);
    expect_pkt({8'h53, 8'h00});
    expect_pkt({8'h82, 8'h04, 8'h00, 8'h00, 8'h3c, 8'h01});
    expect_pkt({8'h82, 8'h04, 8'h02, 8'h02, 8'h3c, 8'h01});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 0;
    key_valid = 0;
    key_code = 8'h00;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    repeat (10) @(negedge clk_sys);
    t_baud;
    t_ping;
    t_bad;
    t_key;
    t_bridge(8'h0e, 8'h54);
    cmp(br_info, {5'h1f, 4'hf, 4'he});
    t_bridge(8'h0f, 8'hd4);
    cmp(br_cnt, 1);
    t_temp;
    end_of_test;
  end
  // Watchdog
  initial begin
    #3_000_000;
    num_errors++;
    end_of_test;
  end
endmodule
bind packet_link link_sva #(.REPORT_CYC(REPORT_CYC), .DIV_SLOW(DIV_SLOW), .DIV_FAST(DIV_FAST))
  sva (.clk_sys, .rst_n, .txd, .temp_refresh, .bridge_req, .bridge_info, .baud_fast);
